// ---- logic/lac_ctrl.sv ----
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "lac_defines.svh"
module lac_ctrl
  import lac_pkg::*;
#(
  parameter int UW = 5,
  parameter int SW = 16
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Frame timing and received PHY header
  input  wire logic          frame_start,
  input  wire logic          rx_hdr_valid,
  input  wire logic [3:0]    rx_rate_request_field,
  input  wire logic [3:0]    rx_rate_indicator_field,
  output logic [3:0]         tx_rate_indicator_field,
  output logic [3:0]         demod_mcs,
  // Uplink SINR samples and requested rate
  input  wire logic          sinr_valid,
  input  wire logic [SW-1:0] sinr_value,
  output logic [3:0]         rate_request_field,
  output logic               low_sinr,
  // Control link channel reception
  input  wire logic          ctrl_rx_ok,
  input  wire logic          ctrl_rx_miss,
  input  wire logic [UW-1:0] ctrl_rx_unit,
  output logic               link_active,
  output logic               active_frame,
  // Switching messages
  input  wire logic          sw_req,
  input  wire logic          sw_confirm,
  output logic               ind_valid,
  output logic [UW-1:0]      ind_unit,
  output logic               ind_same,
  output logic [7:0]         ind_term,
  output logic [7:0]         ind_spec,
  output logic               rel_valid,
  output logic [UW-1:0]      rel_unit
);

  localparam int NU = 1 << UW;

  typedef struct packed {
    logic             hreadyout;
    logic [31:0]      hrdata;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [7:0]       sched_term;
    logic [7:0]       sched_spec;
    logic [NU-1:0]    free_map;
    logic [7:0]       miss_lim;
    logic [3:0]       rate_cap;
    logic [SW-1:0]    sw_thr;
    logic [SW-1:0]    rssi_thr;
    logic [3:0]       avg_shift;
    logic [7:0][SW-1:0] band;
    lac_state_type    state;
    logic [7:0]       act_term;
    logic [7:0]       act_spec;
    logic [7:0]       frame_idx;
    logic             active;
    logic [7:0]       miss_cnt;
    logic [UW-1:0]    cur_unit;
    logic [UW-1:0]    dest_unit;
    logic [3:0]       last_req;
    logic [3:0]       tx_mi;
    logic [3:0]       demod;
    logic             ind_valid;
    logic [UW-1:0]    ind_unit;
    logic             ind_same;
    logic [7:0]       ind_term;
    logic [7:0]       ind_spec;
    logic             rel_valid;
    logic [UW-1:0]    rel_unit;
    logic             no_unit;
    logic             low_sinr;
  } lac_st_type;

  lac_st_type      q;
  lac_st_type      d;
  logic [SW-1:0]   avg;
  logic            avg_valid;
  logic            start_w;
  logic            sched_w;
  logic            found;
  logic [UW-1:0]   pick;
  logic [7:0]      nidx;
  logic [7:0]      term;

  // ----------------------------------------------------------------
  // SINR averaging and rate request
  // ----------------------------------------------------------------
  lac_sinr_avg #(.SW(SW)) u_avg (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sinr_valid(sinr_valid),
    .sinr_value(sinr_value),
    .avg_shift (q.avg_shift),
    .band_thr  (q.band),
    .avg       (avg),
    .rate      (rate_request_field),
    .avg_valid (avg_valid)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Lowest free unit other than the current one
  always_comb begin
    found = 1'b0;
    pick = '0;
    for (int i = NU - 1; i >= 0; i--) begin
      if (q.free_map[i] && UW'(i) != q.cur_unit) begin
        found = 1'b1;
        pick = UW'(i);
      end
    end
  end

  always_comb begin
    d = q;
    d.ind_valid = 1'b0;
    d.rel_valid = 1'b0;
    d.hreadyout = 1'b1;
    start_w = 1'b0;
    sched_w = 1'b0;
    // Register writes land in the data phase
    if (q.wr_pend) begin
      case (q.wr_addr)
        `LAC_OFF_CTRL: begin
          start_w = hwdata[`LAC_CTRL_START];
          sched_w = hwdata[`LAC_CTRL_SCHED];
          if (start_w && q.state == LAC_IDLE) begin
            d.cur_unit = hwdata[`LAC_CTRL_UNIT +: UW];
          end
        end
        `LAC_OFF_SCHED: begin
          d.sched_term = hwdata[7:0];
          d.sched_spec = hwdata[`LAC_SCHED_SPEC +: 8];
        end
        `LAC_OFF_FREE:     d.free_map = hwdata[NU-1:0];
        `LAC_OFF_MISS_LIM: d.miss_lim = hwdata[7:0];
        `LAC_OFF_RATE_CAP: d.rate_cap = hwdata[3:0];
        `LAC_OFF_SW_THR:   d.sw_thr = hwdata[SW-1:0];
        `LAC_OFF_RSSI_THR: d.rssi_thr = hwdata[SW-1:0];
        `LAC_OFF_AVG_CFG:  d.avg_shift = hwdata[3:0];
        default: begin
          if (q.wr_addr[7:5] == 3'(`LAC_OFF_BAND0 >> 5)
              && q.wr_addr[1:0] == 2'b00) begin
            d.band[q.wr_addr[4:2]] = hwdata[SW-1:0];
          end
        end
      endcase
    end
    d.wr_pend = hsel && hready && htrans[1] && hwrite;
    d.wr_addr = haddr[7:0];

    // Header fields: latest request kept, indicator steers demod
    if (rx_hdr_valid) begin
      d.last_req = rx_rate_request_field;
      d.demod = rx_rate_indicator_field;
    end

    // Frame tick: pick downlink rate, never above the request
    term = (q.act_term == 8'h00) ? 8'h01 : q.act_term;
    nidx = (q.frame_idx + 8'h01 >= term) ? 8'h00
                                          : q.frame_idx + 8'h01;
    if (frame_start) begin
      d.tx_mi = (d.last_req < q.rate_cap) ? d.last_req
                                          : q.rate_cap;
      d.frame_idx = nidx;
      d.active = q.state != LAC_IDLE && nidx == q.act_spec;
    end

    if (avg_valid) begin
      d.low_sinr = avg < q.sw_thr;
    end

    // Link supervision
    case (q.state)
      LAC_IDLE: begin
        if (start_w) begin
          d.state = LAC_ACTIVE;
          d.act_term = q.sched_term;
          d.act_spec = q.sched_spec;
          d.frame_idx = 8'h00;
          d.miss_cnt = 8'h00;
        end
      end
      LAC_ACTIVE: begin
        if (sw_req) begin
          d.no_unit = !found;
          if (found) begin
            d.dest_unit = pick;
            d.ind_valid = 1'b1;
            d.ind_unit = pick;
            d.ind_same = 1'b0;
            d.ind_term = q.sched_term;
            d.ind_spec = q.sched_spec;
            d.state = LAC_WAIT_DEST;
          end
        end else if (sched_w) begin
          d.dest_unit = q.cur_unit;
          d.ind_valid = 1'b1;
          d.ind_unit = q.cur_unit;
          d.ind_same = 1'b1;
          d.ind_term = q.sched_term;
          d.ind_spec = q.sched_spec;
          d.state = LAC_WAIT_CONF;
        end
      end
      LAC_WAIT_CONF: begin
        // Mobile confirms only once its schedule is applied
        if (sw_confirm) begin
          d.act_term = q.ind_term;
          d.act_spec = q.ind_spec;
          d.frame_idx = 8'h00;
          d.state = LAC_ACTIVE;
        end
      end
      LAC_WAIT_DEST: begin
        if (ctrl_rx_ok && ctrl_rx_unit == q.dest_unit) begin
          d.rel_valid = 1'b1;
          d.rel_unit = q.cur_unit;
          d.cur_unit = q.dest_unit;
          d.act_term = q.ind_term;
          d.act_spec = q.ind_spec;
          d.frame_idx = 8'h00;
          d.miss_cnt = 8'h00;
          d.state = LAC_ACTIVE;
        end
      end
      default: d.state = LAC_IDLE;
    endcase

    // Misses count only in active frames; release overrides the next state and active flag
    if (q.state != LAC_IDLE && q.active) begin
      if (ctrl_rx_ok && ctrl_rx_unit == q.cur_unit) begin
        d.miss_cnt = 8'h00;
      end else if (ctrl_rx_miss) begin
        if (q.miss_cnt + 8'h01 >= q.miss_lim) begin
          d.state = LAC_IDLE;
          d.rel_valid = 1'b1;
          d.rel_unit = q.cur_unit;
          d.active = 1'b0;
          d.miss_cnt = 8'h00;
        end else begin
          d.miss_cnt = q.miss_cnt + 8'h01;
        end
      end
    end

    // Read mux sees this cycle's writes, so read-after-write is safe
    d.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `LAC_OFF_STATUS: d.hrdata = {8'h00, 3'b000, d.cur_unit,
                                     d.miss_cnt, 4'h0, d.low_sinr,
                                     d.no_unit, d.state};
        `LAC_OFF_SCHED:    d.hrdata = {16'h0000, d.sched_spec,
                                       d.sched_term};
        `LAC_OFF_FREE:     d.hrdata = 32'(d.free_map);
        `LAC_OFF_MISS_LIM: d.hrdata = {24'h000000, d.miss_lim};
        `LAC_OFF_RATE_CAP: d.hrdata = {28'h0000000, d.rate_cap};
        `LAC_OFF_SW_THR:   d.hrdata = 32'(d.sw_thr);
        `LAC_OFF_RSSI_THR: d.hrdata = 32'(d.rssi_thr);
        `LAC_OFF_AVG_CFG:  d.hrdata = {28'h0000000, d.avg_shift};
        `LAC_OFF_SINR:     d.hrdata = {12'h000, rate_request_field,
                                       16'(avg)};
        default: begin
          if (haddr[7:5] == 3'(`LAC_OFF_BAND0 >> 5)) begin
            d.hrdata = 32'(d.band[haddr[4:2]]);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.sched_term <= `LAC_RST_TERM;
      q.sched_spec <= `LAC_RST_SPEC;
      q.miss_lim <= `LAC_RST_MISS_LIM;
      q.rate_cap <= `LAC_RST_RATE_CAP;
      q.avg_shift <= `LAC_RST_AVG_SHIFT;
      for (int k = 0; k < 8; k++) begin
        q.band[k] <= SW'(`LAC_RST_BAND_STEP * (k + 1));
      end
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign tx_rate_indicator_field = q.tx_mi;
  assign demod_mcs = q.demod;
  assign low_sinr = q.low_sinr;
  assign link_active = q.state != LAC_IDLE;
  assign active_frame = q.active;
  assign ind_valid = q.ind_valid;
  assign ind_unit = q.ind_unit;
  assign ind_same = q.ind_same;
  assign ind_term = q.ind_term;
  assign ind_spec = q.ind_spec;
  assign rel_valid = q.rel_valid;
  assign rel_unit = q.rel_unit;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence req_seen_s;
    q.state == LAC_ACTIVE && sw_req && found;
  endsequence
  sequence ind_sent_s;
    ind_valid && !ind_same && ind_unit != q.cur_unit;
  endsequence

  tx_rate_cap_a: assert property (frame_start |=>
    tx_rate_indicator_field <= $past(q.rate_cap) &&
    tx_rate_indicator_field <= $past(d.last_req))
    else $error("tx rate above request or cap");
  tx_rate_req_a: assert property (frame_start &&
    d.last_req <= q.rate_cap |=> tx_rate_indicator_field ==
    $past(d.last_req)) else $error("tx rate not from request");
  demod_follow_a: assert property (rx_hdr_valid |=>
    demod_mcs == $past(rx_rate_indicator_field))
    else $error("demod not from indicator");
  miss_release_a: assert property (q.state != LAC_IDLE &&
    q.active && ctrl_rx_miss && !ctrl_rx_ok &&
    q.miss_cnt + 8'h01 >= q.miss_lim
    |=> !link_active && rel_valid) else $error("no release");
  idle_hold_a: assert property (!link_active && !$past(start_w)
    |-> !active_frame) else $error("idle link has active frame");
  miss_clear_a: assert property (link_active && q.active &&
    ctrl_rx_ok && ctrl_rx_unit == q.cur_unit
    |=> q.miss_cnt == 8'h00) else $error("miss count not cleared");
  inactive_miss_a: assert property (!q.active
    |=> q.miss_cnt == $past(q.miss_cnt) || q.state != $past(q.state))
    else $error("miss counted outside active frame");
  switch_ind_a: assert property (req_seen_s |=> ind_sent_s
    ##1 !ind_valid) else $error("no indication for request");
  ind_source_a: assert property (ind_valid |->
    $past(q.state) == LAC_ACTIVE && ind_term == $past(q.sched_term))
    else $error("indication outside active state");
  dest_success_a: assert property (q.state == LAC_WAIT_DEST &&
    ctrl_rx_ok && ctrl_rx_unit == q.dest_unit && !ctrl_rx_miss
    |=> rel_valid && q.cur_unit == $past(q.dest_unit))
    else $error("switch success not taken");
  low_sinr_a: assert property (avg_valid |=>
    low_sinr == ($past(avg) < $past(q.sw_thr)))
    else $error("low sinr flag wrong");

endmodule

// ---- logic/lac_defines.svh ----
// Behaviour
// - Tx rate follows latest received rate request
// - Base may send any rate up to request
// - Chosen rate written into downlink indicator field
// - Demodulate using received rate indicator field
// - Average SINR over user symbols drives request
// - Bands below A4 map BPSK to 16QAM 1/2
// - Control channel uses only designated active frames
// - Active frames change only via switching indication
// - Indication carries unit, same flag, term, spec
// - N successive misses release the control channel
// - After release both stations go idle
// - Base station monitors uplink control channel SINR
// - Average excludes measurements older than window
// - On request pick unused unit, send indication
// - Uplink on destination means success, release old
`ifndef LAC_DEFINES_SVH
`define LAC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LAC_OFF_CTRL      8'h00
`define LAC_OFF_STATUS    8'h04
`define LAC_OFF_SCHED     8'h08
`define LAC_OFF_FREE      8'h0c
`define LAC_OFF_MISS_LIM  8'h10
`define LAC_OFF_RATE_CAP  8'h14
`define LAC_OFF_SW_THR    8'h18
`define LAC_OFF_RSSI_THR  8'h1c
`define LAC_OFF_AVG_CFG   8'h20
`define LAC_OFF_SINR      8'h24
`define LAC_OFF_BAND0     8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LAC_CTRL_START    0
`define LAC_CTRL_SCHED    1
`define LAC_CTRL_UNIT     8
`define LAC_SCHED_SPEC    8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LAC_RST_MISS_LIM  8'h04
`define LAC_RST_RATE_CAP  4'h8
`define LAC_RST_TERM      8'h04
`define LAC_RST_SPEC      8'h00
`define LAC_RST_AVG_SHIFT 4'h3
`define LAC_RST_BAND_STEP 16'h0100

`endif

// ---- logic/lac_pkg.sv ----
package lac_pkg;

  // Link supervision states
  typedef enum logic [1:0] {
    LAC_IDLE      = 2'b00,
    LAC_ACTIVE    = 2'b01,
    LAC_WAIT_CONF = 2'b10,
    LAC_WAIT_DEST = 2'b11
  } lac_state_type;

  // Modulation and coding codes, ordered by efficiency
  typedef enum logic [3:0] {
    LAC_BPSK_1_2   = 4'h0,
    LAC_QPSK_1_2   = 4'h1,
    LAC_QPSK_3_4   = 4'h2,
    LAC_QAM16_1_2  = 4'h3,
    LAC_QAM16_3_4  = 4'h4,
    LAC_QAM64_4_6  = 4'h5,
    LAC_QAM64_5_6  = 4'h6,
    LAC_QAM256_6_8 = 4'h7,
    LAC_QAM256_7_8 = 4'h8
  } lac_mcs_type;

endpackage

// ---- logic/lac_sinr_avg.sv ----
`timescale 1ns/1ns
`include "lac_defines.svh"
module lac_sinr_avg
  import lac_pkg::*;
#(
  parameter int SW = 16
) (
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // Samples and configuration
  input  wire logic            sinr_valid,
  input  wire logic [SW-1:0]   sinr_value,
  input  wire logic [3:0]      avg_shift,
  input  wire logic [8*SW-1:0] band_thr,
  // Results
  output logic [SW-1:0]        avg,
  output logic [3:0]           rate,
  output logic                 avg_valid
);

  typedef struct packed {
    logic [SW+15:0] acc;
    logic [15:0]    cnt;
    logic [SW-1:0]  avg;
    logic [3:0]     rate;
    logic           valid;
  } lac_avg_st_type;

  lac_avg_st_type q;
  lac_avg_st_type d;
  logic [SW+15:0] sum;
  logic [SW-1:0]  mean;

  // ----------------------------------------------------------------
  // Windowed average and band mapping
  // ----------------------------------------------------------------
  // Block average: each window restarts from zero, so no older
  // measurement leaks into the next result
  always_comb begin
    d = q;
    d.valid = 1'b0;
    sum = q.acc + {{16{1'b0}}, sinr_value};
    mean = SW'(sum >> avg_shift);
    if (sinr_valid) begin
      if (q.cnt == 16'((32'd1 << avg_shift) - 32'd1)) begin
        d.acc = '0;
        d.cnt = '0;
        d.avg = mean;
        d.valid = 1'b1;
        d.rate = 4'h0;
        for (int k = 0; k < 8; k++) begin
          if (mean >= band_thr[k*SW +: SW]) begin
            d.rate = 4'(k + 1);
          end
        end
      end else begin
        d.acc = sum;
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign avg = q.avg;
  assign rate = q.rate;
  assign avg_valid = q.valid;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  low_band_a: assert property (avg_valid && avg < band_thr[SW-1:0]
    |-> rate == LAC_BPSK_1_2) else $error("low band not BPSK");
  top_band_a: assert property (avg_valid &&
    avg >= band_thr[7*SW +: SW] |-> rate == LAC_QAM256_7_8)
    else $error("top band not 256QAM 7/8");
  window_clear_a: assert property (avg_valid |-> q.acc == '0
    && q.cnt == '0) else $error("window not restarted");

endmodule

// ---- testbench/lac_ms_model.sv ----
`timescale 1ns/1ns
module lac_ms_model #(
  parameter int CONF_DLY = 40
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench commands
  input  wire logic       dl_low,
  input  wire logic       fail_rx,
  input  wire logic       carrier_hi,
  // Base station side
  input  wire logic       frame_start,
  input  wire logic       active_frame,
  input  wire logic       ind_valid,
  input  wire logic [4:0] ind_unit,
  input  wire logic       ind_same,
  output logic            sw_req,
  output logic            sw_confirm,
  output logic            ctrl_rx_ok,
  output logic            ctrl_rx_miss,
  output logic [4:0]      ctrl_rx_unit
);
  logic [4:0] unit_q;
  logic       up_q;
  logic       sent_q;
  logic       low_q;
  int         conf_n;

  // One uplink burst per active frame on the unit in use
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_q       <= 5'h03;
      up_q         <= 1'b1;
      sent_q       <= 1'b0;
      low_q        <= 1'b0;
      conf_n       <= 0;
      sw_req       <= 1'b0;
      sw_confirm   <= 1'b0;
      ctrl_rx_ok   <= 1'b0;
      ctrl_rx_miss <= 1'b0;
      ctrl_rx_unit <= 5'h1f;
    end else begin
      low_q        <= dl_low;
      sw_req       <= dl_low && !low_q;
      sw_confirm   <= (conf_n == 1);
      ctrl_rx_ok   <= 1'b0;
      ctrl_rx_miss <= 1'b0;
      // Idle unit bus toggles so a stale value is never trusted
      ctrl_rx_unit <= ~ctrl_rx_unit;
      if (conf_n > 0) begin
        conf_n <= conf_n - 1;
      end
      if (frame_start) begin
        sent_q <= 1'b0;
      end
      // Every schedule is supported, so none is countered
      if (ind_valid && ind_same) begin
        conf_n <= CONF_DLY;
      end
      // Old unit dropped, then carrier sensed on the new one
      if (ind_valid && !ind_same) begin
        unit_q <= ind_unit;
        up_q   <= !carrier_hi;
      end
      if (active_frame && !sent_q && up_q) begin
        sent_q       <= 1'b1;
        ctrl_rx_ok   <= !fail_rx;
        ctrl_rx_miss <= fail_rx;
        ctrl_rx_unit <= unit_q;
      end
    end
  end
endmodule

// ---- testbench/link_adapt_channel_ctrl_tb.sv ----
`timescale 1ns/1ns
module link_adapt_channel_ctrl_tb;
  logic        hclk, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]  htrans = 2'b00, look = 2'd0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        frame_start = 1'b0, rx_hdr_valid = 1'b0;
  logic        sinr_valid = 1'b0, low_sinr, sw_req, sw_confirm;
  logic        ctrl_rx_ok, ctrl_rx_miss, link_active, active_frame;
  logic        ind_valid, ind_same, rel_valid, rd_ph = 1'b0;
  logic        dl_low = 1'b0, fail_rx = 1'b0, carrier_hi = 1'b0;
  logic [3:0]  rx_rate_request_field = 4'h0, rx_rate_indicator_field = 4'h0;
  logic [3:0]  tx_rate_indicator_field, demod_mcs, rate_request_field;
  logic [15:0] sinr_value = 16'h0, v;
  logic [4:0]  ctrl_rx_unit, ind_unit, rel_unit;
  logic [7:0]  ind_term, ind_spec;
  logic [31:0] expq[$];
  int          fails = 0, n_checks = 0, cyc = 0;
  logic [7:0]  ra[8] = '{8'h08, 8'h10, 8'h14, 8'h20, 8'h40, 8'h5c,
                         8'h30, 8'h00};
  logic [31:0] rv[8] = '{32'h4, 32'h4, 32'h8, 32'h3, 32'h100, 32'h800,
                         32'h0, 32'h0};

  lac_ctrl u_dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .frame_start, .rx_hdr_valid, .rx_rate_request_field,
    .rx_rate_indicator_field, .tx_rate_indicator_field, .demod_mcs,
    .sinr_valid, .sinr_value, .rate_request_field, .low_sinr,
    .ctrl_rx_ok, .ctrl_rx_miss, .ctrl_rx_unit, .link_active,
    .active_frame, .sw_req, .sw_confirm, .ind_valid, .ind_unit,
    .ind_same, .ind_term, .ind_spec, .rel_valid, .rel_unit
  );

  lac_ms_model u_ms (
    .hclk, .hresetn, .dl_low, .fail_rx, .carrier_hi, .frame_start,
    .active_frame, .ind_valid, .ind_unit, .ind_same, .sw_req,
    .sw_confirm, .ctrl_rx_ok, .ctrl_rx_miss, .ctrl_rx_unit
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic end_sim();
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] obs);
    logic [31:0] e;
    e = expq.pop_front();
    n_checks++;
    if (obs !== e) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, obs, e);
    end
  endtask

  // Each result that shows up takes the oldest note
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) cmp(hrdata);
    if (ind_valid) cmp({10'h0, ind_same, ind_unit, ind_term, ind_spec});
    if (rel_valid) cmp({27'h0, rel_unit});
    if (look == 2'd1) cmp({24'h0, tx_rate_indicator_field, demod_mcs});
    if (look == 2'd2) cmp({31'h0, link_active});
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hwrite <= wr;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph  <= !wr;
    if (!wr) expq.push_back(d);
    do @(posedge hclk); while (!hreadyout);
    rd_ph  <= 1'b0;
  endtask

  task automatic frame();
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  task automatic peek(input logic [1:0] k, input logic [31:0] e);
    expq.push_back(e);
    look <= k;
    @(posedge hclk);
    look <= 2'd0;
  endtask

  initial begin
    void'($urandom(99));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) bus(1'b0, ra[i], rv[i]);
    // Every code requested, capped at five
    bus(1'b1, 8'h14, 32'h5);
    for (int r = 0; r < 9; r++) begin
      rx_rate_request_field   <= 4'(r);
      rx_rate_indicator_field <= 4'(8 - r);
      rx_hdr_valid            <= 1'b1;
      @(posedge hclk);
      rx_hdr_valid <= 1'b0;
      frame();
      peek(2'd1, {24'h0, (r > 5) ? 4'h5 : 4'(r), 4'(8 - r)});
    end
    // Misses, one good frame, then release after three
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h00, 32'h301);
    fail_rx <= 1'b1;
    repeat (2) frame();
    fail_rx <= 1'b0;
    frame();
    bus(1'b0, 8'h04, 32'h0003_0001);
    fail_rx <= 1'b1;
    repeat (2) frame();
    peek(2'd2, 32'h1);
    expq.push_back(32'h3);
    frame();
    peek(2'd2, 32'h0);
    fail_rx <= 1'b0;
    // Mobile asks to switch; lowest free unit other than 3
    bus(1'b1, 8'h0c, 32'h18);
    bus(1'b1, 8'h00, 32'h301);
    frame();
    expq.push_back({10'h0, 1'b0, 5'd4, 8'h1, 8'h0});
    expq.push_back(32'h3);
    dl_low <= 1'b1;
    repeat (3) frame();
    bus(1'b0, 8'h04, 32'h0004_0001);
    // Same-unit schedule change waits for confirmation
    bus(1'b1, 8'h08, 32'h0102);
    expq.push_back({10'h0, 1'b1, 5'd4, 8'h2, 8'h1});
    bus(1'b1, 8'h00, 32'h2);
    @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0004_0002);
    repeat (50) @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0004_0001);
    // Only the current unit free: request finds nothing
    bus(1'b1, 8'h0c, 32'h10);
    dl_low <= 1'b0;
    frame();
    dl_low <= 1'b1;
    frame();
    bus(1'b0, 8'h04, 32'h0004_0005);
    // Windows of eight samples, first one on a band edge
    bus(1'b1, 8'h18, 32'h400);
    for (int n = 0; n < 4; n++) begin
      v = (n == 0) ? 16'h0300 : 16'($urandom % 32'ha00);
      repeat (8) begin
        sinr_valid <= 1'b1;
        sinr_value <= v;
        @(posedge hclk);
      end
      sinr_valid <= 1'b0;
      repeat (3) @(posedge hclk);
      bus(1'b0, 8'h24, {12'h0, (v > 16'h8ff) ? 4'h8 : v[11:8], v});
      bus(1'b0, 8'h04, (v < 16'h0400) ? 32'h0004_000d : 32'h0004_0005);
    end
    end_sim();
  end
endmodule
